// ---- core/ttpwm_top.sv ----
// Triple timer unit with variable-duty outputs on the first two timers and pulse-width demodulation
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module ttpwm_top #(
  parameter int PSAVE_DIV = ttpwm_pkg::PSAVE_DIV_DEF
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  // Register port
  input  ttpwm_pkg::ttpwm_bus_req_t          bus_req,
  output logic [ttpwm_pkg::DATA_W-1:0]       rd_data,
  // Demodulation input pin
  input  wire logic                          demod_in,
  // Timer outputs
  output logic [ttpwm_pkg::NUM_TMR-1:0]      tmr_out,
  // Interrupt
  output logic                               irq
);

  localparam int CW  = ttpwm_pkg::CNT_W;
  localparam int NT  = ttpwm_pkg::NUM_TMR;
  localparam int NE  = ttpwm_pkg::NUM_EVT;
  localparam int DW  = ttpwm_pkg::DATA_W;
  localparam int AW  = ttpwm_pkg::ADDR_W;
  localparam int PSW = (PSAVE_DIV > 2) ? $clog2(PSAVE_DIV) : 1;
  localparam logic [1:0]     QUARTER_LAST = 2'(ttpwm_pkg::QUARTER_DIV - 1);
  localparam logic [PSW-1:0] PSAVE_LAST   = PSW'(PSAVE_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers
  function automatic logic tmr_sel(input logic [AW-1:0] addr, input int t,
                                   input logic [1:0] r);
    tmr_sel = (addr[7:6] == 2'h0) && (addr[5:4] == 2'(t)) &&
              (addr[3:2] == r) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic sys_sel(input logic [AW-1:0] addr,
                                   input logic [AW-1:0] ofs);
    sys_sel = (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]             quarter_q;
  logic [PSW-1:0]         psave_q;
  logic                   quarter_wrap;
  logic                   tick_q;

  ttpwm_pkg::ttpwm_mode_t mode_q   [NT];
  ttpwm_pkg::ttpwm_mode_t mode_eff [NT];
  logic [CW-1:0]          lim_a_q  [NT];
  logic [CW-1:0]          lim_b_q  [NT];
  logic [CW-1:0]          count    [NT];
  logic [NT-1:0]          level;
  logic [NT-1:0]          full;
  logic [NT-1:0]          load;

  logic [ttpwm_pkg::SYSCFG_W-1:0] syscfg_q;
  logic [NE-1:0]          stat_q;
  logic [NE-1:0]          mask_q;
  logic [NE-1:0]          events;
  logic [NE-1:0]          stat_clr;
  logic [NE-1:0]          stat_d;

  logic                   dm_sync1_q;
  logic                   dm_sync2_q;
  logic                   dm_prev_q;
  logic                   dm_rise;
  logic                   dm_fall;

  logic [DW-1:0]          rd_mux;
  logic [DW-1:0]          rd_data_q;
  logic [NT-1:0]          tmr_out_q;
  logic                   irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Count rate: quarter of the core clock, further slowed in power save
  assign quarter_wrap = (quarter_q == QUARTER_LAST);

  // Free-running divider, never stopped by software
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      quarter_q <= 2'h0;
    end else begin
      quarter_q <= quarter_wrap ? 2'h0 : quarter_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      psave_q <= '0;
    end else if (quarter_wrap) begin
      psave_q <= (psave_q == PSAVE_LAST) ? '0 : psave_q + 1'b1;
    end
  end

  // Registered so every channel steps on the same edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= quarter_wrap &
                (~syscfg_q[ttpwm_pkg::SYSCFG_PSAVE] || psave_q == PSAVE_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer channels with their mode and limit registers
  for (genvar t = 0; t < NT; t++) begin : g_tmr
    localparam bit HAS_B = (t < NT - 1);

    assign load[t] = bus_req.wr && tmr_sel(bus_req.addr, t, ttpwm_pkg::REG_COUNT);

    // The third timer has no limit B and no external count source
    always_comb begin
      mode_eff[t] = mode_q[t];
      if (!HAS_B) begin
        mode_eff[t].alternate = 1'b0;
        mode_eff[t].ext_sel   = 1'b0;
      end
    end

    // A mode write wins over the one-shot enable clear
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        mode_q[t] <= ttpwm_pkg::MODE_RST;
      end else if (bus_req.wr && tmr_sel(bus_req.addr, t, ttpwm_pkg::REG_MODE)) begin
        mode_q[t] <= bus_req.wdata[ttpwm_pkg::MODE_W-1:0];
      end else if (full[t] && !mode_q[t].continuous) begin
        mode_q[t].enable <= 1'b0;
      end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        lim_a_q[t] <= ttpwm_pkg::LIMIT_RST;
      end else if (bus_req.wr && tmr_sel(bus_req.addr, t, ttpwm_pkg::REG_LIMA)) begin
        lim_a_q[t] <= bus_req.wdata[CW-1:0];
      end
    end

    // Limit B writes to the third timer are dropped
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        lim_b_q[t] <= ttpwm_pkg::LIMIT_RST;
      end else if (HAS_B && bus_req.wr &&
                   tmr_sel(bus_req.addr, t, ttpwm_pkg::REG_LIMB)) begin
        lim_b_q[t] <= bus_req.wdata[CW-1:0];
      end
    end

    // The first two channels may step on the third timer's full pulse
    ttpwm_channel #(
      .CNT_W (CW),
      .HAS_B (HAS_B)
    ) u_chan (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .tick     (tick_q),
      .ext_tick (full[NT-1]),
      .mode     (mode_eff[t]),
      .limit_a  (lim_a_q[t]),
      .limit_b  (lim_b_q[t]),
      .load     (load[t]),
      .load_val (bus_req.wdata[CW-1:0]),
      .count    (count[t]),
      .level    (level[t]),
      .full     (full[t])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // System configuration
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      syscfg_q <= ttpwm_pkg::SYSCFG_RST;
    end else if (bus_req.wr && sys_sel(bus_req.addr, ttpwm_pkg::OFS_SYSCFG)) begin
      syscfg_q <= bus_req.wdata[ttpwm_pkg::SYSCFG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Demodulation input: two-stage synchroniser, then edge detection
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dm_sync1_q <= 1'b0;
      dm_sync2_q <= 1'b0;
      dm_prev_q  <= 1'b0;
    end else begin
      dm_sync1_q <= demod_in;
      dm_sync2_q <= dm_sync1_q;
      dm_prev_q  <= dm_sync2_q;
    end
  end

  // Edges are logged only while demodulation is enabled
  assign dm_rise = syscfg_q[ttpwm_pkg::SYSCFG_PWD] & dm_sync2_q & ~dm_prev_q;
  assign dm_fall = syscfg_q[ttpwm_pkg::SYSCFG_PWD] & ~dm_sync2_q & dm_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and request
  assign events   = {dm_fall, dm_rise, full};
  // Only the bits that the read returns are cleared
  assign stat_clr = (bus_req.rd && sys_sel(bus_req.addr, ttpwm_pkg::OFS_STAT)) ?
                    stat_q : '0;
  // A new event in the clearing cycle stays set
  assign stat_d   = (stat_q & ~stat_clr) | events;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= ttpwm_pkg::MASK_RST;
    end else if (bus_req.wr && sys_sel(bus_req.addr, ttpwm_pkg::OFS_MASK)) begin
      mask_q <= bus_req.wdata[NE-1:0];
    end
  end

  // Tracks the status of the same edge, so no extra lag
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  always_comb begin
    rd_mux = '0;
    for (int t = 0; t < NT; t++) begin
      if (tmr_sel(bus_req.addr, t, ttpwm_pkg::REG_MODE)) begin
        rd_mux = DW'(mode_q[t]);
      end
      if (tmr_sel(bus_req.addr, t, ttpwm_pkg::REG_COUNT)) begin
        rd_mux = DW'(count[t]);
      end
      if (tmr_sel(bus_req.addr, t, ttpwm_pkg::REG_LIMA)) begin
        rd_mux = DW'(lim_a_q[t]);
      end
      if (t < NT - 1 && tmr_sel(bus_req.addr, t, ttpwm_pkg::REG_LIMB)) begin
        rd_mux = DW'(lim_b_q[t]);
      end
    end
    if (sys_sel(bus_req.addr, ttpwm_pkg::OFS_SYSCFG)) begin
      rd_mux = DW'(syscfg_q);
    end
    if (sys_sel(bus_req.addr, ttpwm_pkg::OFS_STAT)) begin
      rd_mux = DW'(stat_q);
    end
    if (sys_sel(bus_req.addr, ttpwm_pkg::OFS_MASK)) begin
      rd_mux = DW'(mask_q);
    end
  end

  // Read data stand for one cycle, zero otherwise
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= '0;
    end else if (bus_req.rd) begin
      rd_data_q <= rd_mux;
    end else begin
      rd_data_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Pin levels come straight from a flip-flop
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tmr_out_q <= '0;
    end else begin
      tmr_out_q <= level;
    end
  end

  assign rd_data = rd_data_q;
  assign tmr_out = tmr_out_q;
  assign irq     = irq_q;

endmodule

// ---- common/ttpwm_pkg.sv ----
// Shared constants and types of the triple timer unit
package ttpwm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int NUM_TMR = 3;
  localparam int NUM_EVT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: timers at a stride of 16 bytes, then system registers
  localparam logic [1:0] REG_MODE  = 2'h0;
  localparam logic [1:0] REG_COUNT = 2'h1;
  localparam logic [1:0] REG_LIMA  = 2'h2;
  localparam logic [1:0] REG_LIMB  = 2'h3;
  localparam logic [7:0] OFS_SYSCFG = 8'h30;
  localparam logic [7:0] OFS_STAT   = 8'h34;
  localparam logic [7:0] OFS_MASK   = 8'h38;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MODE_W       = 4;
  localparam int SYSCFG_PWD   = 0;
  localparam int SYSCFG_PSAVE = 1;
  localparam int SYSCFG_W     = 2;
  localparam int STAT_RISE    = 3;
  localparam int STAT_FALL    = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [MODE_W-1:0]   MODE_RST   = 4'h0;
  localparam logic [SYSCFG_W-1:0] SYSCFG_RST = 2'h0;
  localparam logic [NUM_EVT-1:0]  MASK_RST   = 5'h00;
  localparam logic [CNT_W-1:0]    LIMIT_RST  = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: counting rate is one quarter of the core clock
  localparam int QUARTER_DIV   = 4;
  localparam int PSAVE_DIV_DEF = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic ext_sel;
    logic alternate;
    logic continuous;
    logic enable;
  } ttpwm_mode_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ttpwm_bus_req_t;

endpackage

// ---- core/ttpwm_channel.sv ----
// One 16-bit timer channel with one or two count limits
`timescale 1ns/1ps
module ttpwm_channel #(
  parameter int CNT_W = 16,
  parameter bit HAS_B = 1'b1
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // Count sources
  input  wire logic               tick,
  input  wire logic               ext_tick,
  // Configuration
  input  ttpwm_pkg::ttpwm_mode_t  mode,
  input  wire logic [CNT_W-1:0]   limit_a,
  input  wire logic [CNT_W-1:0]   limit_b,
  // Software count load
  input  wire logic               load,
  input  wire logic [CNT_W-1:0]   load_val,
  // Results
  output logic      [CNT_W-1:0]   count,
  output logic                    level,
  output logic                    full
);

  logic [CNT_W-1:0] count_q;
  logic             use_b_q;
  logic             use_b_d;
  logic             level_q;
  logic             full_q;
  logic             step;
  logic             hit;
  logic             dual;
  logic [CNT_W-1:0] act_lim;

  assign dual    = HAS_B & mode.alternate;
  assign step    = mode.enable & (mode.ext_sel ? ext_tick : tick);
  assign act_lim = (dual && use_b_q) ? limit_b : limit_a;
  assign hit     = step & (count_q == act_lim) & ~load;

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_val;
    end else if (hit) begin
      count_q <= '0;
    end else if (step) begin
      count_q <= count_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit alternation and output level
  always_comb begin
    use_b_d = use_b_q;
    if (!dual) begin
      use_b_d = 1'b0;
    end else if (hit) begin
      use_b_d = ~use_b_q;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      use_b_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      use_b_q <= use_b_d;
      level_q <= mode.enable & ~use_b_d;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      full_q <= 1'b0;
    end else begin
      full_q <= hit;
    end
  end

  assign count = count_q;
  assign level = level_q;
  assign full  = full_q;

endmodule

// ---- verification/ttpwm_top_sva.sv ----
// Port-level assertions for the triple timer unit
`timescale 1ns/1ps
module ttpwm_top_sva (
  // Clock and reset
  input wire logic                         sys_clk,
  input wire logic                         nrst,
  // Register port
  input ttpwm_pkg::ttpwm_bus_req_t         bus_req,
  input wire logic [ttpwm_pkg::DATA_W-1:0] rd_data,
  // Pins
  input wire logic                         demod_in,
  input wire logic [ttpwm_pkg::NUM_TMR-1:0] tmr_out,
  input wire logic                         irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  wire logic rd_stat = bus_req.rd && (bus_req.addr == ttpwm_pkg::OFS_STAT);
  wire logic wr_mask = bus_req.wr && (bus_req.addr == ttpwm_pkg::OFS_MASK);
  wire logic rd_tmr  = bus_req.rd && (bus_req.addr < 8'h30);
  logic [2:0] clr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Recent status reads or mask writes, the only causes of a falling irq
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clr_q <= 3'h0;
    end else begin
      clr_q <= {clr_q[1:0], rd_stat | wr_mask};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_rd_idle;
    !bus_req.rd |=> rd_data == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_unmapped;
    bus_req.rd && bus_req.addr == 8'h3C |=> rd_data == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pre_limb;
    bus_req.rd && bus_req.addr == 8'h2C |=> rd_data == 32'h0;
  endproperty
  a_pre_limb: assert property (p_pre_limb) else $error("prescale second limit seen");
  property p_cnt_w;
    rd_tmr && bus_req.addr[3:0] == 4'h4 |=> rd_data[31:16] == 16'h0;
  endproperty
  a_cnt_w: assert property (p_cnt_w) else $error("count wider than 16 bits");
  property p_mode_w;
    rd_tmr && bus_req.addr[3:0] == 4'h0 |=> rd_data[31:4] == 28'h0;
  endproperty
  a_mode_w: assert property (p_mode_w) else $error("mode read has extra bits");
  property p_cfg_w;
    bus_req.rd && bus_req.addr == ttpwm_pkg::OFS_SYSCFG |=> rd_data[31:2] == 30'h0;
  endproperty
  a_cfg_w: assert property (p_cfg_w) else $error("config read has extra bits");
  property p_mask_off;
    wr_mask && bus_req.wdata[4:0] == 5'h0 |-> ##2 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq high with all masked");
  property p_irq_fall;
    $fell(irq) |-> clr_q != 3'h0;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without clear");
  property p_pwm_hold;
    $changed(tmr_out[0]) |=> $stable(tmr_out[0]) [*3];
  endproperty
  a_pwm_hold: assert property (p_pwm_hold) else $error("output faster than tick");
endmodule

bind ttpwm_top ttpwm_top_sva u_sva (
  .sys_clk  (sys_clk),
  .nrst     (nrst),
  .bus_req  (bus_req),
  .rd_data  (rd_data),
  .demod_in (demod_in),
  .tmr_out  (tmr_out),
  .irq      (irq)
);

// ---- verification/ttpwm_icu_model.sv ----
// Interrupt controller model: counts requests from the timer unit
`timescale 1ns/1ps
module ttpwm_icu_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Request and tally
  input  wire logic irq,
  output int        n_irq
);
  logic irq_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'h0;
      n_irq <= 0;
    end else begin
      irq_q <= irq;
      if (irq && !irq_q) n_irq <= n_irq + 1;
    end
  end
endmodule

// ---- verification/tb_ttpwm_top.sv ----
// Self-checking testbench of the triple timer unit
`timescale 1ns/1ps
module tb_ttpwm_top;
  logic                      sys_clk = 1'h0;
  logic                      nrst = 1'h0;
  logic                      demod_in = 1'h0;
  ttpwm_pkg::ttpwm_bus_req_t bus_req = '0;
  logic [31:0]               rd_data;
  logic [2:0]                tmr_out;
  logic                      irq;
  int                        n_irq;
  int                        n_mismatch = 0;
  int                        n_tests = 0;
  int                        cyc = 0;
  int                        h;
  int                        l;
  logic [31:0]               d;
  logic [31:0]               e;
  logic [7:0]                ra [6] = '{8'h00, 8'h08, 8'h2C, 8'h3C, 8'h30, 8'h38};
  logic [31:0]               rv [6] = '{32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};

  always #5 sys_clk = ~sys_clk;

  ttpwm_top #(.PSAVE_DIV(2)) dut (
    .sys_clk (sys_clk), .nrst (nrst), .bus_req (bus_req), .rd_data (rd_data),
    .demod_in (demod_in), .tmr_out (tmr_out), .irq (irq)
  );
  ttpwm_icu_model u_icu (.sys_clk (sys_clk), .nrst (nrst), .irq (irq), .n_irq (n_irq));

  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task tk;
    @(posedge sys_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    bus_req.wr <= 1'h1;
    bus_req.addr <= a;
    bus_req.wdata <= v;
    @(posedge sys_clk);
    bus_req.wr <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    bus_req.rd <= 1'h1;
    bus_req.addr <= a;
    @(posedge sys_clk);
    bus_req.rd <= 1'h0;
    #1 d = rd_data;
  endtask
  // Count advance between two reads gap cycles apart
  task rate(input logic [7:0] a, input int gap, input logic [15:0] x);
    rd(a);
    e = d;
    repeat (gap - 2) @(posedge sys_clk);
    rd(a);
    chk({16'h0, d[15:0] - e[15:0]}, {16'h0, x});
  endtask
  task meas(input logic v, output int n);
    n = 0;
    while (tmr_out[0] === v && n < 100) begin
      tk();
      n++;
    end
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'h1;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      chk(d, rv[i]);
    end
    wr(8'h0C, 32'h3);
    rd(8'h0C);
    chk(d, 32'h3);
    wr(8'h2C, 32'h7);
    rd(8'h2C);
    chk(d, 32'h0);
    wr(8'h10, 32'h3);
    rd(8'h10);
    chk(d, 32'h3);
    rate(8'h14, 40, 16'h000A);
    wr(8'h30, 32'h2);
    rate(8'h14, 80, 16'h000A);
    wr(8'h30, 32'h0);
    // Third timer as prescaler of the second
    wr(8'h28, 32'h3);
    wr(8'h20, 32'h3);
    wr(8'h10, 32'hB);
    rate(8'h14, 64, 16'h0004);
    repeat (40) tk();
    chk({31'h0, irq}, 32'h0);
    wr(8'h38, 32'h4);
    for (h = 0; h < 40 && irq !== 1'h1; h++) tk();
    chk({31'h0, irq}, 32'h1);
    rd(ttpwm_pkg::OFS_STAT);
    chk({31'h0, d[2]}, 32'h1);
    wr(8'h38, 32'h0);
    repeat (3) tk();
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, n_irq > 0}, 32'h1);
    // Dual limits on the first timer: high 4 ticks, low 2 ticks
    wr(8'h08, 32'h3);
    wr(8'h0C, 32'h1);
    wr(8'h00, 32'h7);
    meas(1'h0, l);
    meas(1'h1, h);
    meas(1'h0, l);
    meas(1'h1, h);
    chk(h, 32'h10);
    chk(l, 32'h8);
    // One-shot prescaler stops itself after its next full count
    wr(8'h20, 32'h1);
    repeat (24) tk();
    rd(8'h20);
    chk(d, 32'h0);
    chk({30'h0, tmr_out[2:1]}, 32'h1);
    // Demodulation edges, first with the enable off
    rd(ttpwm_pkg::OFS_STAT);
    @(posedge sys_clk) demod_in <= 1'h1;
    repeat (8) tk();
    rd(ttpwm_pkg::OFS_STAT);
    chk({31'h0, d[3]}, 32'h0);
    @(posedge sys_clk) demod_in <= 1'h0;
    repeat (8) tk();
    wr(ttpwm_pkg::OFS_SYSCFG, 32'h1);
    @(posedge sys_clk) demod_in <= 1'h1;
    repeat (8) tk();
    rd(ttpwm_pkg::OFS_STAT);
    chk({31'h0, d[3]}, 32'h1);
    @(posedge sys_clk) demod_in <= 1'h0;
    repeat (8) tk();
    rd(ttpwm_pkg::OFS_STAT);
    chk({31'h0, d[4]}, 32'h1);
    rd(ttpwm_pkg::OFS_STAT);
    chk({31'h0, d[4]}, 32'h0);
    end_sim();
  end
endmodule
